/* verification/sram_burst_port_tb.sv */
// self-checking bench for the burst sram port
`timescale 1ns/10ps
module sram_burst_port_tb;
    // codes {wd, suspend, adv, rw, a_n, b, c_n, lanes}
    localparam logic [10:0] LDR = 11'h0af, LDW = 11'h020, ADV = 11'h12f, ADW = 11'h5a0;
    localparam logic [10:0] DSA = 11'h4ef, DSB = 11'h08f, DSC = 11'h0bf, SUS = 11'h220;
    localparam logic [35:0] D = 36'hab0000000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic lin = 1'b1;
    logic oe_n = 1'b0;
    sram_port_pkg::req_t req;
    logic [3:0] ce;
    logic [35:0] wdat;
    logic [35:0] data_o;
    logic data_oe_o;
    int n_mismatch = 0;
    int compares = 0;
    always #20 clk = ~clk;
    sram_ctl_model ctl_u (.clk_i(clk), .req_o(req), .ce_o(ce), .wdata_o(wdat));
    sram_burst_port dut_u
    (
        .clk_i(clk), .rst_n_i(rst_n), .clock_suspend_n_i(ce[3]),
        .advance_or_load_i(req.load_n), .read_write_i(req.write_n),
        .burst_order_select_i(lin), .chip_select_a_n_i(ce[2]), .chip_select_b_i(ce[1]),
        .chip_select_c_n_i(ce[0]), .output_enable_n_i(oe_n), .addr_i(req.addr),
        .lane_write_n_i(req.lane_n), .data_i(wdat), .data_o(data_o), .data_oe_o(data_oe_o)
    );
    task automatic chk(input logic e, input logic [35:0] d);
        compares++;
        if (data_oe_o !== e || (e && data_o !== d))
        begin
            n_mismatch++;
            $display("BAD %0t data %h drive %b", $time, data_o, data_oe_o);
        end
    endtask
    // linear from low bits 2 fills 12,13,10,11
    task automatic s_write();
        ctl_u.beat(LDW, 17'h00012, D);
        for (int i = 0; i < 3; i++)
        begin
            ctl_u.beat(ADW, 17'h00000, D + 36'(i));
            chk(1'b0, D);
        end
        ctl_u.beat(DSA, 17'h00000, D + 36'h3);
    endtask
    // interleaved from 11 reads back in reverse; suspended edge would be a write
    task automatic s_read();
        lin = 1'b0;
        ctl_u.beat(LDR, 17'h00011, D);
        ctl_u.beat(SUS, 17'h00000, D);
        for (int i = 0; i < 6; i++)
        begin
            ctl_u.beat(i < 3 ? ADV : (i == 3 ? DSB : DSC), 17'h00000, D);
            if (i > 0)
                chk(i < 5, D + 36'(4 - i));
        end
    endtask
    task automatic s_lane();
        ctl_u.beat(LDW, 17'h00020, D);
        ctl_u.beat(11'h42a, 17'h00020, 36'hfffffffff);
        ctl_u.beat(DSA, 17'h00000, 36'h000000000);
        ctl_u.beat(LDR, 17'h00020, D);
        ctl_u.beat(ADV, 17'h00000, D);
        ctl_u.beat(DSB, 17'h00000, D);
        chk(1'b1, 36'hff803fe00);
        oe_n = 1'b1;
        ctl_u.beat(DSC, 17'h00000, D);
        chk(1'b0, D);
        oe_n = 1'b0;
    endtask
    task automatic final_report();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        s_write();
        s_read();
        s_lane();
        final_report();
    end
    initial
    begin
        #8000;
        n_mismatch++;
        final_report();
    end
endmodule // sram_burst_port_tb

/* verification/sram_ctl_model.sv */
// controller model that drives the port one beat at a time
`timescale 1ns/10ps
module sram_ctl_model
(
    input  wire logic           clk_i,
    output sram_port_pkg::req_t req_o,
    output logic [3:0]          ce_o,
    output logic [35:0]         wdata_o
);
    // ****
    // beat
    // ****
    // c = {wd, suspend, adv, rw, a_n, b, c_n, lanes}
    task automatic beat(input logic [10:0] c, input logic [16:0] a, input logic [35:0] d);
        @(negedge clk_i);
        ce_o = {c[9], c[6:4]};
        req_o = {c[8], c[7], a, c[3:0]};
        // released bus flips so a stale word never looks valid
        wdata_o = c[10] ? d : ~wdata_o;
    endtask
    initial
    begin
        ce_o = 4'h6;
        req_o = '0;
        wdata_o = '0;
    end
endmodule // sram_ctl_model

/* verification/sram_port_properties.sv */
// pin checks for the burst sram port
`timescale 1ns/10ps
module sram_port_properties
(
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        clock_suspend_n_i,
    input wire logic        advance_or_load_i,
    input wire logic        read_write_i,
    input wire logic        chip_select_a_n_i,
    input wire logic        chip_select_b_i,
    input wire logic        chip_select_c_n_i,
    input wire logic        output_enable_n_i,
    input wire logic [35:0] data_o,
    input wire logic        data_oe_o
);
    wire run = !clock_suspend_n_i;
    wire sel = !chip_select_a_n_i && chip_select_b_i && !chip_select_c_n_i;
    wire ld = run && !advance_or_load_i;
    wire rd = ld && sel && read_write_i;
    wire adv = run && advance_or_load_i;
    wire seen = data_oe_o || output_enable_n_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    oe_float_a: assert property (output_enable_n_i |-> !data_oe_o)
        else $error("driven with oe off");
    read_answer_a: assert property (rd ##1 run |=> seen)
        else $error("read data missing");
    read_suspend_a: assert property (rd ##1 !run ##1 run |=> seen)
        else $error("read lost over suspend");
    burst_dir_a: assert property (rd ##1 (adv && !read_write_i) ##1 run |=> seen)
        else $error("burst direction changed");
    pending_done_a: assert property (rd ##1 adv ##1 (ld && !sel) |=> seen)
        else $error("pending read dropped");
    write_quiet_a: assert property ((ld && sel && !read_write_i) ##1 run |=> !data_oe_o)
        else $error("driven in write phase");
    desel_float_a: assert property ((ld && !sel) ##1 run |=> !data_oe_o)
        else $error("driven after deselect");
    suspend_hold_a: assert property (!run |=> $stable(data_o))
        else $error("suspend moved data");
    cover property (rd ##1 run ##1 data_oe_o);
    cover property ((ld && !read_write_i) ##1 run);
    cover property (!run ##1 run);
endmodule // sram_port_properties
bind sram_burst_port sram_port_properties chk_u (.*);

/* verilog/sram_burst_port.sv */
// synchronous burst sram port with registered read data
// Notes on behaviour
// - sampling advance_or_load low ends any burst and loads new address
// - read-write select ignored on advance edges
// - burst direction fixed by read-write select at load
// - only the two low address bits step, four words per base
// - load with read-write low starts a write, high a read
// - lane selects sampled one clock before their write data
// - clock_suspend_n high makes the edge count as absent
// - any chip enable inactive at load starts a deselect cycle
// - data bus floats one cycle after a deselect edge
// - access loaded before deselect still completes its data phase
// - one chip enable active high, two active low
// - selected only when both low enables low and high enable high
// - read data driven two edges after load when output enable low
`timescale 1ns/10ps
`include "sram_port_map.svh"
module sram_burst_port
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 clock_suspend_n_i,
    input  wire logic                 advance_or_load_i,
    input  wire logic                 read_write_i,
    input  wire logic                 burst_order_select_i,
    input  wire logic                 chip_select_a_n_i,
    input  wire logic                 chip_select_b_i,
    input  wire logic                 chip_select_c_n_i,
    input  wire logic                 output_enable_n_i,
    input  wire logic [`ADDR_W-1:0]   addr_i,
    input  wire logic [`LANE_N-1:0]   lane_write_n_i,
    input  wire logic [`DATA_W-1:0]   data_i,
    output logic      [`DATA_W-1:0]   data_o,
    output logic                      data_oe_o
);
    // ****************************************************************
    // state
    // ****************************************************************
    // phase names the data cycle that follows the last taken edge; base,
    // step and linear name the beat in flight; lane holds the strobes for
    // the write word that arrives on the next edge
    typedef struct packed
    {
        sram_port_pkg::phase_t  phase;
        logic [`ADDR_W-1:0]     base;
        logic [1:0]             step;
        logic                   linear;
        logic [`LANE_N-1:0]     lane;
        logic [`DATA_W-1:0]     dout;
        logic                   drive;
    } state_t;

    state_t state_r;
    state_t state_nxt;
    logic   [`ADDR_W-1:0] cur_addr;
    logic   [`DATA_W-1:0] rdata;
    logic                 mem_we;
    logic                 selected;
    logic                 load;
    logic                 active;

    logic                 rd_beat;
    logic                 wr_beat;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // low address bits of the beat in flight
    function automatic logic [1:0] burst_lo(input logic [1:0] base, input logic [1:0] step,
                                            input logic linear);
        burst_lo = linear ? 2'(base + step) : (base ^ step);
    endfunction

    // the three enables at their own active levels
    function automatic logic chip_selected(input logic a_n, input logic b, input logic c_n);
        chip_selected = !a_n && b && !c_n;
    endfunction

    // lane pins are active low, the stored strobes active high
    function automatic logic [`LANE_N-1:0] lanes_of(input logic [`LANE_N-1:0] lane_n);
        lanes_of = ~lane_n;
    endfunction

    // access kind picked on a load edge; a deselect wins over direction
    function automatic sram_port_pkg::phase_t load_phase(input logic sel, input logic rd);
        if (!sel)
        begin
            load_phase = sram_port_pkg::PH_IDLE;
        end
        else if (rd)
        begin
            load_phase = sram_port_pkg::PH_READ;
        end
        else
        begin
            load_phase = sram_port_pkg::PH_WRITE;
        end
    endfunction

    // shared by the store strobe and the output flop
    function automatic logic phase_is(input sram_port_pkg::phase_t ph,
                                      input sram_port_pkg::phase_t want);
        phase_is = ph == want;
    endfunction

    // ****************************************************************
    // decode
    // ****************************************************************
    assign selected = chip_selected(chip_select_a_n_i, chip_select_b_i, chip_select_c_n_i);
    assign load     = !advance_or_load_i;
    // the suspend pin is a run enable: low lets the edge through
    assign active   = clock_suspend_n_i == 1'b0;
    assign cur_addr = {state_r.base[`ADDR_W-1:2],
                       burst_lo(state_r.base[1:0], state_r.step, state_r.linear)};
    assign rd_beat  = active && phase_is(state_r.phase, sram_port_pkg::PH_READ);
    assign wr_beat  = active && phase_is(state_r.phase, sram_port_pkg::PH_WRITE);
    // write lands in the data cycle, with lanes caught the edge before
    assign mem_we   = wr_beat;

    sram_word_store u_store
    (
        .clk_i   (clk_i),
        .we_i    (mem_we),
        .lane_i  (state_r.lane),
        .addr_i  (cur_addr),
        .wdata_i (data_i),
        .rdata_o (rdata)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    // the reset term keeps the case quiet while the flops still hold unknowns
    always_comb
    begin
        state_nxt = state_r;
        if (active && rst_n_i)
        begin
            // address side: a load ends any burst, an advance steps it
            if (load)
            begin
                state_nxt.base   = addr_i;
                state_nxt.step   = 2'h0;
                state_nxt.linear = burst_order_select_i == `ORDER_LINEAR;
                state_nxt.lane   = lanes_of(lane_write_n_i);
                state_nxt.phase  = load_phase(selected, read_write_i);
            end
            else
            begin
                // direction kept, read_write_i not looked at here
                unique case (state_r.phase)
                    sram_port_pkg::PH_IDLE:
                    begin
                        // an advance with no burst open changes nothing
                        state_nxt.step = state_r.step;
                    end
                    sram_port_pkg::PH_READ,
                    sram_port_pkg::PH_WRITE:
                    begin
                        state_nxt.step = 2'(state_r.step + 2'h1);
                        state_nxt.lane = lanes_of(lane_write_n_i);
                    end
                endcase
            end
            // data side: the access taken on the previous edge completes now
            state_nxt.dout  = `RST_DATA;
            state_nxt.drive = 1'b0;
            unique case (state_r.phase)
                sram_port_pkg::PH_READ:
                begin
                    // registered so data_o comes from a flop, one cycle late
                    state_nxt.dout  = rdata;
                    state_nxt.drive = rd_beat;
                end
                sram_port_pkg::PH_WRITE:
                begin
                    // bus stays with the controller; the store takes data_i
                    state_nxt.drive = 1'b0;
                end
                sram_port_pkg::PH_IDLE:
                begin
                    // deselected or never loaded: the bus floats
                    state_nxt.drive = 1'b0;
                end
            endcase
        end
    end

    // only the port state is reset; the array keeps whatever it holds
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            state_r.phase  <= sram_port_pkg::PH_IDLE;
            state_r.base   <= `RST_ADDR;
            state_r.step   <= 2'h0;
            state_r.linear <= 1'b0;
            state_r.lane   <= '0;
            state_r.dout   <= `RST_DATA;
            state_r.drive  <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // data_o trails its load by two edges: one to take the address and
    // one to register the array word; a controller must allow for it
    // output enable gates drive asynchronously; a flop cannot follow it
    assign data_o    = state_r.dout;
    assign data_oe_o = state_r.drive && !output_enable_n_i;
endmodule // sram_burst_port

/* verilog/sram_port_map.svh */
// constants for the burst sram port
`ifndef SRAM_PORT_MAP_SVH
`define SRAM_PORT_MAP_SVH
`define ADDR_W        17
`define DATA_W        36
`define LANE_N        4
`define LANE_W        9
`define DEPTH         131072
`define BURST_LO_W    2
`define ORDER_LINEAR  1'b1
`define RST_ADDR      17'h00000
`define RST_DATA      36'h000000000
`endif

/* verilog/sram_port_pkg.sv */
// types shared by the burst sram port
package sram_port_pkg;
    typedef enum logic [2:0]
    {
        PH_IDLE  = 3'b001,
        PH_READ  = 3'b010,
        PH_WRITE = 3'b100
    } phase_t;

    typedef struct packed
    {
        logic        load_n;
        logic        write_n;
        logic [16:0] addr;
        logic [3:0]  lane_n;
    } req_t;
endpackage

/* verilog/sram_word_store.sv */
// word array with per-lane write and flow-through read
`timescale 1ns/10ps
`include "sram_port_map.svh"
module sram_word_store
(
    input  wire logic                 clk_i,
    input  wire logic                 we_i,
    input  wire logic [`LANE_N-1:0]   lane_i,
    input  wire logic [`ADDR_W-1:0]   addr_i,
    input  wire logic [`DATA_W-1:0]   wdata_i,
    output logic      [`DATA_W-1:0]   rdata_o
);
    logic [`DATA_W-1:0] mem [0:`DEPTH-1];

    // no reset: array content is undefined at power-up like the real part
    always_ff @(posedge clk_i)
    begin
        for (int i = 0; i < `LANE_N; i++)
        begin
            if (we_i && lane_i[i])
            begin
                mem[addr_i][i*`LANE_W +: `LANE_W] <= wdata_i[i*`LANE_W +: `LANE_W];
            end
        end
    end

    assign rdata_o = mem[addr_i];
endmodule // sram_word_store
